// File: design/pcu_change_det.sv
// Per-pin synchroniser and change detector
`timescale 1ns/100ps
`include "pcu_map.svh"

module pcu_change_det #(
  parameter int WIDTH = 8
) (
  input  wire logic             clock,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] changed,
  output logic      [WIDTH-1:0] synced
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] prev_d;

  // ========================================================================
  // Two-stage synchroniser then previous sample
  always_comb begin
    meta_d = pin;
    sync_d = meta_q;
    prev_d = sync_q;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= '0;
      sync_q <= '0;
      prev_q <= '0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
      prev_q <= prev_d;
    end
  end

  // ========================================================================
  // Any toggle, rising or falling, counts
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_bit
      assign changed[g] = sync_q[g] ^ prev_q[g];
    end
  endgenerate

  // Settled pin view for the asynchronous wake compare
  assign synced = sync_q;

endmodule : pcu_change_det

// File: design/pcu_map.svh
// Register offsets, field positions and reset values of the pin-change unit
`ifndef PCU_MAP_SVH
`define PCU_MAP_SVH

// ==========================================================================
// Data-space offsets, the I/O-to-data shift and the top I/O offset
`define PCU_OFS_FLAGS      8'h3B
`define PCU_OFS_MASK_LOW   8'h6B
`define PCU_OFS_MASK_MID   8'h6C
`define PCU_OFS_MASK_HIGH  8'h6D
`define PCU_OFS_GROUP_EN   8'h68
`define PCU_IO_SHIFT       8'h20
`define PCU_IO_TOP         8'h3F

// ==========================================================================
// Field positions and the mask of implemented middle-mask bits
`define PCU_GROUP0_BIT     0
`define PCU_GROUP1_BIT     1
`define PCU_GROUP2_BIT     2
`define PCU_MID_IMPL       8'h7F

// ==========================================================================
// Reset values
`define PCU_RST_REG        8'h00
`define PCU_RST_GROUP      3'h0

`endif

// File: design/pcu_pkg.sv
// Types shared by the pin-change unit
package pcu_pkg;

  // ========================================================================
  // Register bus request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic       io_space;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pcu_bus_req_t;

  // ========================================================================
  // Register selected by a decode
  typedef enum logic [2:0] {
    PCU_SEL_NONE,
    PCU_SEL_FLAGS,
    PCU_SEL_MASK_LOW,
    PCU_SEL_MASK_MID,
    PCU_SEL_MASK_HIGH,
    PCU_SEL_GROUP_EN
  } pcu_sel_t;

endpackage : pcu_pkg

// File: design/pcu_top.sv
// Pin-change interrupt unit: registers, group requests and flags
`timescale 1ns/100ps
`include "pcu_map.svh"

module pcu_top #(
  parameter int PINS = 24
) (
  input  wire logic                 clock,
  input  wire logic                 rst_n,
  input  wire logic [PINS-1:0]      change_source_pin,
  input  wire logic                 core_global_ie,
  input  wire pcu_pkg::pcu_bus_req_t bus_req,
  output logic      [7:0]           bus_rdata,
  output logic                      bus_hit,
  output logic                      group0_vector,
  output logic                      group1_vector,
  output logic                      group2_vector,
  input  wire logic [2:0]           vector_ack,
  output logic                      wake_request
);

  // ========================================================================
  // Registers
  logic [7:0] mask_low_q;
  logic [7:0] mask_low_d;
  logic [7:0] mask_mid_q;
  logic [7:0] mask_mid_d;
  logic [7:0] mask_high_q;
  logic [7:0] mask_high_d;
  logic [2:0] group_en_q;
  logic [2:0] group_en_d;
  logic [2:0] flags_q;
  logic [2:0] flags_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic       hit_q;
  logic       hit_d;

  logic [PINS-1:0] changed;
  logic [PINS-1:0] synced;
  logic [PINS-1:0] enabled_pins;
  logic [2:0]      group_hit;
  logic [2:0]      group_vec;
  logic [7:0]      data_addr;
  pcu_pkg::pcu_sel_t sel;

  // ========================================================================
  // Change detection; pins are sampled whatever their direction
  // The synchronised view also feeds the wake compare
  pcu_change_det #(
    .WIDTH (PINS)
  ) u_det (
    .clock   (clock),
    .rst_n   (rst_n),
    .pin     (change_source_pin),
    .changed (changed),
    .synced  (synced)
  );

  // ========================================================================
  // Mask and group enable combine per pin
  // Group 1 has seven pins, so pin 15 never contributes
  always_comb begin
    enabled_pins         = '0;
    enabled_pins[7:0]    = mask_low_q & {8{group_en_q[`PCU_GROUP0_BIT]}};
    enabled_pins[14:8]   = mask_mid_q[6:0] & {7{group_en_q[`PCU_GROUP1_BIT]}};
    enabled_pins[23:16]  = mask_high_q & {8{group_en_q[`PCU_GROUP2_BIT]}};
    group_hit[0] = |(changed[7:0] & enabled_pins[7:0]);
    group_hit[1] = |(changed[14:8] & enabled_pins[14:8]);
    group_hit[2] = |(changed[23:16] & enabled_pins[23:16]);
  end

  // Wake path bypasses the clock: raw pins against last synced view
  // It stands only while the synchroniser lags the pin
  assign wake_request = |(enabled_pins & (change_source_pin ^ synced));

  // ========================================================================
  // Address decode, I/O space sits 0x20 below data space
  // I/O offsets above the top of I/O space select nothing
  always_comb begin
    data_addr = bus_req.addr;
    if (bus_req.io_space) begin
      data_addr = (bus_req.addr <= `PCU_IO_TOP) ? 8'(bus_req.addr + `PCU_IO_SHIFT)
                                               : 8'h00;
    end
    unique case (data_addr)
      `PCU_OFS_FLAGS:     sel = pcu_pkg::PCU_SEL_FLAGS;
      `PCU_OFS_MASK_LOW:  sel = pcu_pkg::PCU_SEL_MASK_LOW;
      `PCU_OFS_MASK_MID:  sel = pcu_pkg::PCU_SEL_MASK_MID;
      `PCU_OFS_MASK_HIGH: sel = pcu_pkg::PCU_SEL_MASK_HIGH;
      `PCU_OFS_GROUP_EN:  sel = pcu_pkg::PCU_SEL_GROUP_EN;
      default:            sel = pcu_pkg::PCU_SEL_NONE;
    endcase
  end

  // ========================================================================
  // Configuration writes: masks and group enables
  always_comb begin
    logic wr;
    wr          = bus_req.wr;
    mask_low_d  = mask_low_q;
    mask_mid_d  = mask_mid_q;
    mask_high_d = mask_high_q;
    group_en_d  = group_en_q;
    if (wr && sel == pcu_pkg::PCU_SEL_MASK_LOW) begin
      mask_low_d = bus_req.wdata;
    end
    // Bit 7 of the middle mask has no pin and stays zero
    if (wr && sel == pcu_pkg::PCU_SEL_MASK_MID) begin
      mask_mid_d = bus_req.wdata & `PCU_MID_IMPL;
    end
    if (wr && sel == pcu_pkg::PCU_SEL_MASK_HIGH) begin
      mask_high_d = bus_req.wdata;
    end
    // Enable bits above group 2 are not implemented
    if (wr && sel == pcu_pkg::PCU_SEL_GROUP_EN) begin
      group_en_d = bus_req.wdata[2:0];
    end
  end

  // All state comes up zero, so no group can request after reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mask_low_q  <= `PCU_RST_REG;
      mask_mid_q  <= `PCU_RST_REG;
      mask_high_q <= `PCU_RST_REG;
      group_en_q  <= `PCU_RST_GROUP;
    end else begin
      mask_low_q  <= mask_low_d;
      mask_mid_q  <= mask_mid_d;
      mask_high_q <= mask_high_d;
      group_en_q  <= group_en_d;
    end
  end

  // ========================================================================
  // Group flags
  always_comb begin
    logic [2:0] clr;
    // Clears from the core and from software merge into one mask
    clr = vector_ack;
    if (bus_req.wr && sel == pcu_pkg::PCU_SEL_FLAGS) begin
      clr = clr | bus_req.wdata[2:0];
    end
    // A new change wins over any clear in the same cycle
    flags_d = (flags_q & ~clr) | group_hit;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags_q <= `PCU_RST_GROUP;
    end else begin
      flags_q <= flags_d;
    end
  end

  // ========================================================================
  // Read data
  // Flags and enables read back zero above bit 2
  always_comb begin
    hit_d   = (bus_req.rd || bus_req.wr) && (sel != pcu_pkg::PCU_SEL_NONE);
    rdata_d = rdata_q;
    if (bus_req.rd) begin
      unique case (sel)
        pcu_pkg::PCU_SEL_FLAGS:     rdata_d = {5'h0, flags_q};
        pcu_pkg::PCU_SEL_MASK_LOW:  rdata_d = mask_low_q;
        pcu_pkg::PCU_SEL_MASK_MID:  rdata_d = mask_mid_q;
        pcu_pkg::PCU_SEL_MASK_HIGH: rdata_d = mask_high_q;
        pcu_pkg::PCU_SEL_GROUP_EN:  rdata_d = {5'h0, group_en_q};
        pcu_pkg::PCU_SEL_NONE:      rdata_d = 8'h00;
      endcase
    end
  end

  // ========================================================================
  // Bus response registers
  // bus_hit lasts one cycle; read data holds until the next read
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= `PCU_RST_REG;
      hit_q   <= 1'b0;
    end else begin
      rdata_q <= rdata_d;
      hit_q   <= hit_d;
    end
  end

  // Both bus outputs come straight from flip-flops
  assign bus_rdata = rdata_q;
  assign bus_hit   = hit_q;

  // ========================================================================
  // Vectored requests, one per group, standing while the flag, the group enable and core_global_ie are all set
  // The core acknowledges each group on its own vector
  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_vec
      assign group_vec[gi] = flags_q[gi] & group_en_q[gi] & core_global_ie;
    end
  endgenerate

  assign group0_vector = group_vec[`PCU_GROUP0_BIT];
  assign group1_vector = group_vec[`PCU_GROUP1_BIT];
  assign group2_vector = group_vec[`PCU_GROUP2_BIT];

endmodule : pcu_top

// File: dv/pcu_core_model.sv
// Core-side model that services vectored requests with an acknowledge
`timescale 1ns/100ps
module pcu_core_model (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       service_en,
  input  wire logic       slow,
  input  wire logic [2:0] vector,
  output logic      [2:0] vector_ack
);
  logic [3:0] cnt_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q      <= 4'h0;
      vector_ack <= 3'h0;
    end else begin
      vector_ack <= 3'h0;
      cnt_q      <= (service_en && vector != 3'h0) ? cnt_q + 4'h1 : 4'h0;
      // Lowest pending group first, one pulse per service
      if (cnt_q == (slow ? 4'h8 : 4'h1)) begin
        vector_ack <= vector & (~vector + 3'h1);
        cnt_q      <= 4'h0;
      end
    end
  end
endmodule : pcu_core_model

// File: dv/pcu_monitor.sv
// Port assertions of the pin-change unit
`timescale 1ns/100ps
module pcu_monitor #(
  parameter int PINS = 24
) (
  input wire logic                  clock,
  input wire logic                  rst_n,
  input wire logic [PINS-1:0]       change_source_pin,
  input wire logic                  core_global_ie,
  input wire pcu_pkg::pcu_bus_req_t bus_req,
  input wire logic [7:0]            bus_rdata,
  input wire logic                  bus_hit,
  input wire logic                  group0_vector,
  input wire logic                  group1_vector,
  input wire logic                  group2_vector,
  input wire logic [2:0]            vector_ack,
  input wire logic                  wake_request
);
  logic [2:0]      quiet_q, quiet_d, vec;
  logic [PINS-1:0] pin_q;
  logic            calm, io_ok, flg, hit;
  always_comb begin
    vec     = {group2_vector, group1_vector, group0_vector};
    quiet_d = (change_source_pin != pin_q) ? 3'h0 : quiet_q + 3'(quiet_q != 3'h7);
    calm    = quiet_q > 3'h4 && change_source_pin == pin_q;
    io_ok   = !bus_req.io_space || bus_req.addr <= 8'h3F;
    flg     = bus_req.addr == (bus_req.io_space ? 8'h1B : 8'h3B);
    hit     = flg || !bus_req.io_space && bus_req.addr inside {8'h68, [8'h6B:8'h6D]};
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      quiet_q <= 3'h0;
      pin_q   <= '0;
    end else begin
      quiet_q <= quiet_d;
      pin_q   <= change_source_pin;
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  ie_gate_a:
    assert property (vec != 3'h0 |-> core_global_ie) else $error("vector without enable");
  ack_clear_a:
    assert property (vector_ack != 3'h0 && calm |=> ($past(vector_ack) & vec) == 3'h0)
      else $error("ack kept vector");
  one_clear_a:
    assert property (bus_req.wr && flg && calm |=> ($past(bus_req.wdata[2:0]) & vec) == 3'h0)
      else $error("write one kept vector");
  rise_cause_a:
    assert property ((vec & ~$past(vec)) != 3'h0 && $stable(core_global_ie) && !$past(bus_req.wr)
      |-> quiet_q != 3'h7) else $error("vector rose without change");
  fall_cause_a:
    assert property ((~vec & $past(vec)) != 3'h0 |-> $past(vector_ack) != 3'h0
      || $past(bus_req.wr) || !core_global_ie) else $error("vector fell without cause");
  bus_hit_a:
    assert property (io_ok |=> bus_hit == $past(hit && (bus_req.rd || bus_req.wr)))
      else $error("hit flag wrong");
  miss_zero_a:
    assert property (bus_req.rd && io_ok && !hit |=> bus_rdata == 8'h00) else $error("miss read");
  mid_top_a:
    assert property (bus_req.rd && !bus_req.io_space && bus_req.addr == 8'h6C |=> !bus_rdata[7])
      else $error("mid mask bit 7 set");
  reset_idle_a:
    assert property (!$past(rst_n) |-> vec == 3'h0) else $error("vector after reset");
endmodule : pcu_monitor

bind pcu_top pcu_monitor #(
  .PINS (PINS)
) mon_u (
  .clock             (clock),
  .rst_n             (rst_n),
  .change_source_pin (change_source_pin),
  .core_global_ie    (core_global_ie),
  .bus_req           (bus_req),
  .bus_rdata         (bus_rdata),
  .bus_hit           (bus_hit),
  .group0_vector     (group0_vector),
  .group1_vector     (group1_vector),
  .group2_vector     (group2_vector),
  .vector_ack        (vector_ack),
  .wake_request      (wake_request)
);

// File: dv/tb.sv
// Self-checking bench of the pin-change unit
`timescale 1ns/100ps
module tb;
  logic                  clock = 1'b0;
  logic                  rst_n = 1'b0;
  logic                  gie = 1'b0;
  logic                  svc = 1'b0;
  logic                  slow = 1'b0;
  logic                  wake, hit;
  logic [2:0]            vec, ack;
  logic [7:0]            rdata;
  logic [23:0]           pins = 24'h00_0000;
  logic [7:0]            regs [5] = '{8'h3B, 8'h68, 8'h6B, 8'h6C, 8'h6D};
  pcu_pkg::pcu_bus_req_t req = '0;
  int                    err_count = 0;
  int                    total_checks = 0;

  always #20 clock = ~clock;

  pcu_top dut_u (.clock(clock), .rst_n(rst_n), .change_source_pin(pins), .core_global_ie(gie),
    .bus_req(req), .bus_rdata(rdata), .bus_hit(hit), .group0_vector(vec[0]),
    .group1_vector(vec[1]), .group2_vector(vec[2]), .vector_ack(ack), .wake_request(wake));
  pcu_core_model core_u (.clock(clock), .rst_n(rst_n), .service_en(svc), .slow(slow),
    .vector(vec), .vector_ack(ack));

  task automatic conclude;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : conclude

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic acc(input logic w, input logic io, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    req <= '{wr: w, rd: !w, io_space: io, addr: a, wdata: d};
    @(posedge clock);
    req <= '0;
    #1;
  endtask : acc

  function automatic logic exp_hit(input logic io, input logic [7:0] a);
    return io ? (a == 8'h1B) : (a inside {8'h3B, 8'h68, 8'h6B, 8'h6C, 8'h6D});
  endfunction : exp_hit

  task automatic rd(input logic io, input logic [7:0] a, input logic [7:0] exp);
    acc(1'b0, io, a, 8'h00);
    chk(rdata, exp);
    chk({7'h00, hit}, {7'h00, exp_hit(io, a)});
  endtask : rd

  task automatic tog(input int p, input logic w);
    @(posedge clock);
    pins[p] <= ~pins[p];
    #1 chk({7'h00, wake}, {7'h00, w});
    repeat (5) @(posedge clock);
    #1;
  endtask : tog

  initial begin
    logic [7:0] m;
    int         b;
    void'($urandom(16654));
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    foreach (regs[i]) rd(1'b0, regs[i], 8'h00);
    rd(1'b0, 8'h50, 8'h00);
    $display("test 1 done");
    for (int g = 0; g < 3; g++) begin
      m = 8'($urandom);
      acc(1'b1, 1'b0, 8'h6B + 8'(g), m);
      rd(1'b0, 8'h6B + 8'(g), g == 1 ? m & 8'h7F : m);
    end
    $display("test 2 done");
    gie <= 1'b1;
    acc(1'b1, 1'b0, 8'h68, 8'h07);
    for (int g = 0; g < 3; g++) begin
      b = $urandom % 7;
      acc(1'b1, 1'b0, 8'h6B + 8'(g), 8'h01 << b);
      tog(g * 8 + (b + 1) % 7, 1'b0);
      rd(1'b0, 8'h3B, 8'h00);
      tog(g * 8 + b, 1'b1);
      rd(1'b0, 8'h3B, 8'h01 << g);
      chk({5'h00, vec}, 8'h01 << g);
      acc(1'b1, 1'b1, 8'h1B, 8'h00);
      rd(1'b1, 8'h1B, 8'h01 << g);
      acc(1'b1, 1'b1, 8'h1B, 8'h01 << g);
      rd(1'b0, 8'h3B, 8'h00);
    end
    $display("test 3 done");
    tog(16 + b, 1'b1);
    gie <= 1'b0;
    #1 chk({5'h00, vec}, 8'h00);
    rd(1'b0, 8'h3B, 8'h04);
    acc(1'b1, 1'b0, 8'h3B, 8'h04);
    gie <= 1'b1;
    svc <= 1'b1;
    for (int s = 0; s < 2; s++) begin
      slow <= s[0];
      tog(16 + b, 1'b1);
      for (int i = 0; i < 40 && vec[2]; i++) begin
        @(posedge clock);
        #1;
      end
      if (vec[2]) begin
        $display("BAD %0t wait expired", $time);
        err_count++;
        conclude();
      end
      rd(1'b0, 8'h3B, 8'h00);
    end
    $display("test 4 done");
    svc <= 1'b0;
    tog(16 + b, 1'b1);
    chk({5'h00, vec}, 8'h04);
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    #1 chk({5'h00, vec}, 8'h00);
    foreach (regs[i]) rd(1'b0, regs[i], 8'h00);
    $display("test 5 done");
    conclude();
  end
endmodule : tb
